// ### core/mrs_pkg.sv
// ********************************************************
// Shared constants and carriers of the request sequencer
// ********************************************************
package mrs_pkg;

    // Port counts and queue sizes
    localparam int MRS_MAX_PORTS = 16; // Expansion ceiling
    localparam int MRS_PORTS = 10; // Default memory ports
    localparam int MRS_QDEPTH = 10; // Pending request slots
    localparam int MRS_FIFO_DEPTH = 4; // Ingress buffer words
    localparam int MRS_BANKS = 4; // Chip selects per memory kind
    localparam int MRS_ROW_W = 13; // Row address bits, 8K rows

    // Ports 3 to 6 are the wide ones with extended signalling
    localparam logic [15:0] MRS_WIDE_PORTS = 16'h0078;

    // Transfer sizes and responses, AHB encoding
    localparam logic [2:0] MRS_SIZE_WORD = 3'h2;
    localparam logic [2:0] MRS_SIZE_DWORD = 3'h3;
    localparam logic [1:0] MRS_RESP_OKAY = 2'h0;
    localparam logic [1:0] MRS_RESP_ERROR = 2'h1;

    // Beats of one single-access burst per memory width
    localparam logic [2:0] MRS_BEATS_64 = 3'h1;
    localparam logic [2:0] MRS_BEATS_32 = 3'h2;
    localparam logic [2:0] MRS_BEATS_16 = 3'h4;

    // Row activation wait, least time rounded up
    localparam int MRS_CLK_PERIOD_NS = 50;
    localparam int MRS_ACT_TIME_NS = 20;
    localparam logic [3:0] MRS_ACT_CYCLES =
        4'((MRS_ACT_TIME_NS + MRS_CLK_PERIOD_NS - 1) / MRS_CLK_PERIOD_NS);

    // Width of the external memory bus
    typedef enum logic [1:0] {
        MRS_W16 = 2'b00,
        MRS_W32 = 2'b01,
        MRS_W64 = 2'b10
    } mrs_width_t;

    // Sequencer phases
    typedef enum logic [1:0] {
        MRS_IDLE = 2'b00,
        MRS_ACTWAIT = 2'b01
    } mrs_phase_t;

    // One request as a port presents it
    typedef struct packed {
        logic valid;
        logic write;
        logic lock;
        logic dynamic;
        logic [2:0] burst;
        logic [2:0] size;
        logic [1:0] bank;
        logic [MRS_ROW_W-1:0] row;
    } mrs_req_t;

    // A request tagged with its port
    typedef struct packed {
        logic [3:0] port;
        mrs_req_t req;
    } mrs_item_t;

    // One pending queue slot
    typedef struct packed {
        logic valid;
        logic [7:0] age;
        mrs_item_t item;
    } mrs_entry_t;

    // Command to the memory transfer engine
    typedef struct packed {
        logic valid;
        logic activate;
        logic dynamic;
        logic write;
        logic [1:0] chipSel;
        logic [MRS_ROW_W-1:0] row;
        logic [2:0] beats;
        logic [3:0] port;
    } mrs_cmd_t;

endpackage : mrs_pkg

// ### core/mrs_request_sequencer.sv

// ********************************************************
// Ingress buffer
// ********************************************************
module mrs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clocking
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // Filling side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Draining side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Whole buffer state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] count;
    } mrs_fifo_state_t;

    mrs_fifo_state_t st; // Registered state
    mrs_fifo_state_t next_st; // Next value
    logic push; // Word enters
    logic pop; // Word leaves

    // Honest flags straight from the count
    assign inReady = (st.count != (AW + 1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign outData = st.mem[st.rd];

    // Pointer and count update
    always_comb begin
        next_st = st;
        push = inValid && inReady;
        pop = outValid && outReady;
        if (push) begin
            next_st.mem[st.wr] = inData;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        // Simultaneous push and pop leave the count alone
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule : mrs_fifo

// ********************************************************
// Request sequencer top
// ********************************************************
module mrs_request_sequencer
    import mrs_pkg::*;
#(
    parameter int PORTS = MRS_PORTS,
    parameter int QDEPTH = MRS_QDEPTH,
    parameter logic [15:0] WIDE_MASK = MRS_WIDE_PORTS,
    parameter mrs_width_t MEM_WIDTH = MRS_W32
) (
    // Clocking
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // Memory port requests and answers
    input wire mrs_req_t [PORTS-1:0] reqIn,
    output logic [PORTS-1:0] portGrant,
    output logic [PORTS-1:0] portDone,
    output logic [PORTS-1:0][1:0] portResp,
    // Memory transfer engine command
    output mrs_cmd_t memCmd,
    // Register port, 32-bit AHB
    input wire logic regSel,
    input wire logic [1:0] regTrans,
    input wire logic [2:0] regSize,
    input wire logic regReadyIn,
    output logic regReady,
    output logic [1:0] regResp
);
    // Beats per access follow the external width
    localparam logic [2:0] BEATS = (MEM_WIDTH == MRS_W64) ? MRS_BEATS_64 :
        (MEM_WIDTH == MRS_W32) ? MRS_BEATS_32 : MRS_BEATS_16;

    // Whole block state
    typedef struct packed {
        mrs_entry_t [QDEPTH-1:0] q;
        logic [MRS_BANKS-1:0] rowOpen;
        logic [MRS_BANKS-1:0][MRS_ROW_W-1:0] openRow;
        logic [1:0] actBank;
        logic [3:0] actTimer;
        mrs_phase_t phase;
        logic [2:0] xferCnt;
        logic [3:0] xferPort;
        logic lockHeld;
        logic [3:0] lockPort;
        logic [PORTS-1:0] portBusy;
        logic [PORTS-1:0] portGrant;
        logic [PORTS-1:0] portDone;
        logic [PORTS-1:0][1:0] portResp;
        mrs_cmd_t cmd;
        logic regPhase;
        logic regReady;
        logic [1:0] regResp;
    } mrs_state_t;

    mrs_state_t st; // Registered state
    mrs_state_t next_st; // Next value
    mrs_item_t pushItem; // Word into the buffer
    logic pushValid; // Buffer write strobe
    logic fifoInReady; // Buffer has room
    logic fifoOutValid; // Buffer holds a word
    mrs_item_t fifoOut; // Oldest buffered word
    logic fifoOutReady; // Queue has a free slot
    logic [$clog2(QDEPTH+1)-1:0] occupancy; // Queue fill, checked only

    // Outputs come straight from state
    assign portGrant = st.portGrant;
    assign portDone = st.portDone;
    assign portResp = st.portResp;
    assign memCmd = st.cmd;
    assign regReady = st.regReady;
    assign regResp = st.regResp;

    // Buffer between arbiter and queue; a full queue stalls it
    mrs_fifo #(
        .WIDTH($bits(mrs_item_t)),
        .DEPTH(MRS_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .inValid(pushValid),
        .inData(pushItem),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOut),
        .outReady(fifoOutReady)
    );

    // Cheap transfer: static, or row already open in its bank
    function automatic logic rowHit(input mrs_state_t s, input mrs_req_t r);
        rowHit = !r.dynamic || (s.rowOpen[r.bank] && s.openRow[r.bank] == r.row);
    endfunction : rowHit

    // Priority key: lower port first, then older entry
    function automatic logic beats(input mrs_entry_t a, input mrs_entry_t b);
        beats = (a.item.port < b.item.port) ||
            (a.item.port == b.item.port && a.age > b.age);
    endfunction : beats

    // Next-state logic of the whole block
    always_comb begin
        logic regValid;
        logic found;
        int win;
        logic sizeBad;
        logic freeFound;
        int freeIdx;
        logic bestFound;
        int best;
        logic hitFound;
        int hit;
        logic xferFree;
        regValid = 1'b0;
        found = 1'b0;
        win = 0;
        sizeBad = 1'b0;
        freeFound = 1'b0;
        freeIdx = 0;
        bestFound = 1'b0;
        best = 0;
        hitFound = 1'b0;
        hit = 0;
        xferFree = 1'b0;
        occupancy = '0;
        next_st = st;
        next_st.portGrant = '0;
        next_st.portDone = '0;
        next_st.portResp = '0;
        next_st.cmd = '0;
        pushValid = 1'b0;
        pushItem = '0;

        // Register port answers; no registers behind it
        regValid = regSel && regTrans[1] && regReadyIn;
        if (st.regPhase) begin
            // Second cycle of the two-cycle error
            next_st.regPhase = 1'b0;
            next_st.regReady = 1'b1;
            next_st.regResp = MRS_RESP_ERROR;
        end else if (regValid && regSize != MRS_SIZE_WORD) begin
            next_st.regPhase = 1'b1;
            next_st.regReady = 1'b0;
            next_st.regResp = MRS_RESP_ERROR;
        end else begin
            next_st.regReady = 1'b1;
            next_st.regResp = MRS_RESP_OKAY;
        end

        // Port arbiter, scanned down so the lowest index wins
        for (int i = PORTS - 1; i >= 0; i--) begin
            if (reqIn[i].valid && !st.portBusy[i] && !st.portGrant[i] &&
                    (!st.lockHeld || st.lockPort == 4'(i))) begin
                found = 1'b1;
                win = i;
            end
        end
        if (found && fifoInReady) begin
            next_st.portGrant[win] = 1'b1;
            // Wide ports take doublewords, narrow ones words
            sizeBad = reqIn[win].size >
                (WIDE_MASK[win] ? MRS_SIZE_DWORD : MRS_SIZE_WORD);
            if (sizeBad) begin
                next_st.portDone[win] = 1'b1;
                next_st.portResp[win] = MRS_RESP_ERROR;
            end else begin
                // Any burst kind passes through unchanged
                pushValid = 1'b1;
                pushItem.port = 4'(win);
                pushItem.req = reqIn[win];
                next_st.portBusy[win] = 1'b1;
            end
            // Lock holds the grant until an unlocked transfer
            next_st.lockHeld = reqIn[win].lock;
            next_st.lockPort = 4'(win);
        end

        // Queue ageing and the free slot for the buffer head
        for (int i = QDEPTH - 1; i >= 0; i--) begin
            if (st.q[i].valid) begin
                occupancy = occupancy + 1'b1;
                if (st.q[i].age != 8'hff) begin
                    next_st.q[i].age = st.q[i].age + 1'b1;
                end
            end else begin
                freeFound = 1'b1;
                freeIdx = i;
            end
        end
        fifoOutReady = freeFound;
        if (fifoOutValid && freeFound) begin
            next_st.q[freeIdx].valid = 1'b1;
            next_st.q[freeIdx].age = '0;
            next_st.q[freeIdx].item = fifoOut;
        end

        // Favoured entry, and best cheap entry outside the opening bank
        for (int i = 0; i < QDEPTH; i++) begin
            if (st.q[i].valid) begin
                if (!bestFound || beats(st.q[i], st.q[best])) begin
                    bestFound = 1'b1;
                    best = i;
                end
                if (rowHit(st, st.q[i].item.req) &&
                        !(st.phase == MRS_ACTWAIT && st.q[i].item.req.dynamic &&
                        st.q[i].item.req.bank == st.actBank) &&
                        (!hitFound || beats(st.q[i], st.q[hit]))) begin
                    hitFound = 1'b1;
                    hit = i;
                end
            end
        end

        // Running burst; its last beat answers the port
        xferFree = (st.xferCnt <= 3'h1);
        if (st.xferCnt != '0) begin
            next_st.xferCnt = st.xferCnt - 1'b1;
            if (st.xferCnt == 3'h1) begin
                next_st.portDone[st.xferPort] = 1'b1;
                next_st.portResp[st.xferPort] = MRS_RESP_OKAY;
                next_st.portBusy[st.xferPort] = 1'b0;
            end
        end

        // Command choice
        case (st.phase)
            MRS_IDLE: begin
                if (bestFound && rowHit(st, st.q[best].item.req)) begin
                    if (xferFree) begin
                        hit = best;
                        hitFound = 1'b1;
                    end else begin
                        hitFound = 1'b0;
                    end
                end else if (bestFound) begin
                    // Open the favoured row first
                    hitFound = 1'b0;
                    next_st.cmd.valid = 1'b1;
                    next_st.cmd.activate = 1'b1;
                    next_st.cmd.dynamic = 1'b1;
                    next_st.cmd.chipSel = st.q[best].item.req.bank;
                    next_st.cmd.row = st.q[best].item.req.row;
                    next_st.cmd.port = st.q[best].item.port;
                    next_st.rowOpen[st.q[best].item.req.bank] = 1'b1;
                    next_st.openRow[st.q[best].item.req.bank] =
                        st.q[best].item.req.row;
                    next_st.actBank = st.q[best].item.req.bank;
                    next_st.actTimer = MRS_ACT_CYCLES;
                    next_st.phase = MRS_ACTWAIT;
                end else begin
                    hitFound = 1'b0;
                end
            end
            MRS_ACTWAIT: begin
                // Open-row work fills the activation gap
                if (st.actTimer != '0) begin
                    next_st.actTimer = st.actTimer - 1'b1;
                end else begin
                    next_st.phase = MRS_IDLE;
                end
                hitFound = hitFound && xferFree;
            end
            default: begin
                hitFound = 1'b0;
                next_st.phase = MRS_IDLE;
            end
        endcase

        // Issue one single-access burst
        if (hitFound) begin
            next_st.cmd.valid = 1'b1;
            next_st.cmd.activate = 1'b0;
            next_st.cmd.dynamic = st.q[hit].item.req.dynamic;
            next_st.cmd.write = st.q[hit].item.req.write;
            next_st.cmd.chipSel = st.q[hit].item.req.bank;
            next_st.cmd.row = st.q[hit].item.req.row;
            next_st.cmd.beats = BEATS;
            next_st.cmd.port = st.q[hit].item.port;
            next_st.q[hit].valid = 1'b0;
            next_st.xferCnt = BEATS;
            next_st.xferPort = st.q[hit].item.port;
        end
    end

    // State register; AHB ready stays high through reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0;
            st.regReady <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn || !ce);

    // Helper: register access that must draw an error
    logic regValid_q;
    assign regValid_q = regSel && regTrans[1] && regReadyIn && regReady &&
        regSize != MRS_SIZE_WORD;

    sequence s_reg_err_first;
        !regReady && regResp == MRS_RESP_ERROR;
    endsequence

    sequence s_reg_err_second;
        regReady && regResp == MRS_RESP_ERROR;
    endsequence

    a_reg_err_pair: assert property (
        regValid_q |=> s_reg_err_first ##1 s_reg_err_second)
        else $error("non-word register access not answered by two-cycle ERROR");

    a_reg_word_okay: assert property (
        (regSel && regTrans[1] && regReadyIn && regReady &&
        regSize == MRS_SIZE_WORD) |=> regReady && regResp == MRS_RESP_OKAY)
        else $error("word register access not answered OKAY");

    a_resp_only_okerr: assert property (
        portDone != '0 |-> (portResp & {PORTS{2'b10}}) == '0)
        else $error("memory port answered SPLIT or RETRY");

    a_grant_onehot: assert property (
        $onehot0(portGrant))
        else $error("more than one port granted at once");

    a_burst_beats: assert property (
        memCmd.valid && !memCmd.activate |-> memCmd.beats == BEATS)
        else $error("burst length does not match memory width");

    a_act_then_wait: assert property (
        memCmd.valid && memCmd.activate |-> st.phase == MRS_ACTWAIT
        ##1 st.phase == MRS_IDLE || st.actTimer == '0)
        else $error("activate not followed by the wait phase");

    a_hit_other_bank: assert property (
        st.phase == MRS_ACTWAIT && next_st.cmd.valid && next_st.cmd.dynamic &&
        st.actTimer != '0 |-> next_st.cmd.chipSel != st.actBank)
        else $error("access to bank still opening");

    a_queue_bound: assert property (
        occupancy <= QDEPTH)
        else $error("queue holds more than its depth");

    a_lock_owner: assert property (
        st.lockHeld |-> (next_st.portGrant & ~(PORTS'(1) << st.lockPort)) == '0)
        else $error("grant left a locked port");

    a_narrow_size_err: assert property (
        st.portGrant[0] && !WIDE_MASK[0] && $past(reqIn[0].size) > MRS_SIZE_WORD
        |-> portDone[0] && portResp[0] == MRS_RESP_ERROR)
        else $error("oversized access on narrow port not refused");
endmodule : mrs_request_sequencer

// ### testbench/mrs_master_model.sv
// ********************************************************
// Bus masters on the memory ports
// ********************************************************
module mrs_master_model
    import mrs_pkg::*;
#(
    parameter int PORTS = MRS_PORTS
) (
    // Clocking
    input wire logic core_clk,
    // Requests toward the sequencer
    output mrs_req_t [PORTS-1:0] reqIn,
    // Answers from the sequencer
    input wire logic [PORTS-1:0] portGrant,
    input wire logic [PORTS-1:0] portDone
);
    timeunit 1ns;
    timeprecision 1ns;

    // Expected answers per port, oldest first
    logic [1:0] expQ [PORTS][$];

    // Idle masters at time zero
    initial reqIn = '0;

    // One request: hold until grant is sampled, then wait for done
    task automatic issue(input int p, input mrs_req_t r);
        logic [2:0] maxSize;
        logic gotDone;
        maxSize = MRS_WIDE_PORTS[p] ? MRS_SIZE_DWORD : MRS_SIZE_WORD;
        expQ[p].push_back((r.size > maxSize) ? MRS_RESP_ERROR : MRS_RESP_OKAY);
        r.valid = 1'b1;
        @(negedge core_clk);
        reqIn[p] = r;
        do @(posedge core_clk); while (portGrant[p] !== 1'b1);
        gotDone = portDone[p];
        @(negedge core_clk);
        // Released lines flip so stale values never look valid
        reqIn[p] = ~r;
        reqIn[p].valid = 1'b0;
        while (gotDone !== 1'b1) begin
            @(posedge core_clk);
            gotDone = portDone[p];
        end
    endtask : issue

endmodule : mrs_master_model

// ### testbench/mrs_request_sequencer_tb.sv
// ********************************************************
// Self-checking bench of the request sequencer
// ********************************************************
module mrs_request_sequencer_tb;
    import mrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int PORTS = 10; // Default port mix
    logic core_clk = 1'b0; // 20 MHz clock
    logic rstn = 1'b0; // Active low reset
    logic ce = 1'b1; // Clock enable, always run
    mrs_req_t [PORTS-1:0] reqIn; // From the master model
    logic [PORTS-1:0] portGrant;
    logic [PORTS-1:0] portDone;
    logic [PORTS-1:0][1:0] portResp;
    mrs_cmd_t memCmd;
    logic regSel = 1'b0; // Register port strobes
    logic [1:0] regTrans = 2'h0;
    logic [2:0] regSize = 3'h0;
    logic regReadyIn;
    logic regReady;
    logic [1:0] regResp;
    int badCount = 0; // Mismatches
    int checks = 0; // Comparisons
    int grantLog [$]; // Ports in grant order
    mrs_cmd_t expCmd [$]; // Expected engine commands
    logic cmdWatch = 1'b0; // Command compare window

    // Single slave on the register bus: ready loops back
    assign regReadyIn = regReady;

    always #25 core_clk = ~core_clk;

    mrs_request_sequencer dut_u (
        .core_clk(core_clk), .rstn(rstn), .ce(ce), .reqIn(reqIn),
        .portGrant(portGrant), .portDone(portDone), .portResp(portResp),
        .memCmd(memCmd), .regSel(regSel), .regTrans(regTrans),
        .regSize(regSize), .regReadyIn(regReadyIn), .regReady(regReady),
        .regResp(regResp)
    );

    mrs_master_model #(.PORTS(PORTS)) mst_u (
        .core_clk(core_clk), .reqIn(reqIn), .portGrant(portGrant),
        .portDone(portDone)
    );

    // ********************************************************
    // Comparison and closing
    // ********************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrapUp();
        $display("Checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrapUp

    // Legal random request; lock off, any burst type
    function automatic mrs_req_t randReq(input int p);
        mrs_req_t r;
        r = $bits(mrs_req_t)'($urandom);
        r.lock = 1'b0;
        r.size = 3'($urandom_range(MRS_WIDE_PORTS[p] ? 3 : 2));
        return r;
    endfunction : randReq

    // Dynamic request to one bank and row, word sized
    function automatic mrs_req_t dynReq(input logic [1:0] bank, input logic [12:0] row);
        mrs_req_t r;
        r = '0;
        r.dynamic = 1'b1;
        r.size = MRS_SIZE_WORD;
        r.bank = bank;
        r.row = row;
        return r;
    endfunction : dynReq

    // One register access, answer checked cycle by cycle
    task automatic regAccess(input logic [2:0] sz, input logic [1:0] tr);
        logic taken;
        taken = tr[1];
        @(negedge core_clk);
        regSel = 1'b1;
        regTrans = tr;
        regSize = sz;
        @(negedge core_clk);
        regSel = 1'b0;
        regTrans = 2'h0;
        regSize = ~sz;
        check("reg ready c1", regReady, !(taken && sz != MRS_SIZE_WORD));
        check("reg resp c1", regResp, (taken && sz != MRS_SIZE_WORD));
        if (taken && sz != MRS_SIZE_WORD) begin
            @(negedge core_clk);
            check("reg ready c2", regReady, 1'b1);
            check("reg resp c2", regResp, MRS_RESP_ERROR);
        end
    endtask : regAccess

    // ********************************************************
    // Output watcher: answers, grants, commands
    // ********************************************************
    always @(negedge core_clk) begin
        mrs_cmd_t e;
        for (int p = 0; p < PORTS; p++) begin
            if (portGrant[p] === 1'b1) grantLog.push_back(p);
            if (portDone[p] === 1'b1) begin
                if (mst_u.expQ[p].size() == 0) begin
                    check("unexpected done", 1'b1, 1'b0);
                end else begin
                    check("port response", portResp[p], mst_u.expQ[p].pop_front());
                end
            end
        end
        if (cmdWatch && memCmd.valid === 1'b1) begin
            if (expCmd.size() == 0) begin
                check("extra command", 1'b1, 1'b0);
            end else begin
                e = expCmd.pop_front();
                check("cmd activate", memCmd.activate, e.activate);
                check("cmd chip select", memCmd.chipSel, e.chipSel);
                check("cmd row", memCmd.row, e.row);
                if (!e.activate) begin
                    check("cmd port", memCmd.port, e.port);
                    check("cmd beats", memCmd.beats, MRS_BEATS_32);
                end
            end
        end
    end

    // Watchdog well beyond the expected run
    initial begin
        #(50 * 20000);
        badCount++;
        $display("ERROR watchdog expected finish seen hang");
        wrapUp();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        mrs_req_t r;
        void'($urandom(89362));
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        check("reset ready", regReady, 1'b1);
        check("reset resp", regResp, MRS_RESP_OKAY);
        check("reset grant", portGrant, '0);
        check("reset cmd", memCmd.valid, 1'b0);
        $display("Test reset finished");
        // Oversize refused, largest legal size accepted, every port
        for (int p = 0; p < PORTS; p++) begin
            r = randReq(p);
            r.size = MRS_WIDE_PORTS[p] ? 3'($urandom_range(7, 4)) : 3'($urandom_range(7, 3));
            mst_u.issue(p, r);
            r.size = MRS_WIDE_PORTS[p] ? MRS_SIZE_DWORD : MRS_SIZE_WORD;
            mst_u.issue(p, r);
        end
        $display("Test sizes finished");
        // All ports at once: grant count and grants by index
        grantLog = {};
        for (int p = 0; p < PORTS; p++) begin
            automatic int q = p;
            fork
                mst_u.issue(q, randReq(q));
            join_none
        end
        wait fork;
        check("grant count", grantLog.size(), PORTS);
        foreach (grantLog[i]) check("grant order", grantLog[i], i);
        $display("Test priority finished");
        // Open a row in bank 0 and a different row in bank 1
        mst_u.issue(2, dynReq(2'h0, 13'h0005));
        mst_u.issue(1, dynReq(2'h1, 13'h0003));
        expCmd = '{'{valid: 1'b1, activate: 1'b1, chipSel: 2'h1, row: 13'h0004, default: '0},
                   '{valid: 1'b1, chipSel: 2'h0, row: 13'h0005, port: 4'h2, default: '0},
                   '{valid: 1'b1, chipSel: 2'h1, row: 13'h0004, port: 4'h1, default: '0}};
        cmdWatch = 1'b1;
        fork
            mst_u.issue(1, dynReq(2'h1, 13'h0004));
            mst_u.issue(2, dynReq(2'h0, 13'h0005));
        join
        repeat (4) @(negedge core_clk);
        cmdWatch = 1'b0;
        check("commands left", expCmd.size(), 0);
        $display("Test reorder finished");
        // Locked sequence keeps other ports out until unlocked
        grantLog = {};
        r = randReq(5);
        r.lock = 1'b1;
        fork
            begin
                mst_u.issue(5, r);
                mst_u.issue(5, r);
                mst_u.issue(5, randReq(5));
            end
            begin
                repeat (3) @(negedge core_clk);
                mst_u.issue(0, randReq(0));
            end
        join
        check("lock grants", grantLog.size(), 4);
        foreach (grantLog[i]) check("lock order", grantLog[i], (i < 3) ? 5 : 0);
        $display("Test lock finished");
        // Register port: sizes 0 to 3, then busy and sequential kinds
        for (int s = 0; s < 4; s++) regAccess(3'(s), 2'h2);
        regAccess(MRS_SIZE_WORD, 2'h1);
        regAccess(3'h1, 2'h3);
        $display("Test register finished");
        repeat (4) @(negedge core_clk);
        for (int p = 0; p < PORTS; p++) check("answers left", mst_u.expQ[p].size(), 0);
        wrapUp();
    end

endmodule : mrs_request_sequencer_tb
